// ===== rtl/lpcal_pkg.sv
// Purpose: Shared constants, states and carriers of the low-power calibration sequencer
// Assumes: AXI4-Lite register access with 32-bit data and 12-bit byte addresses
// Notes:   Register byte address is four times the register index
package lpcal_pkg;

   // ************************************************************
   // Bus and counter widths
   // ************************************************************
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned CNT_W  = 48;

   // ************************************************************
   // Register map (indices) and reset values
   // ************************************************************
   localparam logic [9:0] IDX_LP_CTRL = 10'h06E;
   localparam logic [9:0] IDX_VEC_EN  = 10'h070;
   localparam logic [9:0] IDX_CFG     = 10'h080;
   localparam logic [9:0] IDX_STATUS  = 10'h081;
   localparam logic [7:0] LP_CTRL_RST = 8'h88;
   localparam logic [7:0] VEC_EN_RST  = 8'h00;
   localparam logic [7:0] CFG_RST     = 8'h04;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int unsigned SLEEP_LSB    = 5;
   localparam int unsigned SETTLE_LSB   = 3;
   localparam int unsigned WAKE_TRG_BIT = 1;
   localparam int unsigned LP_ON_BIT    = 0;
   localparam int unsigned VEC_EN_BIT   = 0;
   localparam int unsigned BG_ON_BIT    = 0;
   localparam int unsigned SRC_SEL_BIT  = 1;
   localparam int unsigned SOFT_TRG_BIT = 2;

   // ************************************************************
   // Interval timing: (2^k + 1) * unit clock periods
   // ************************************************************
   localparam logic [47:0] SLEEP_EXP_TBL  = {6'h21, 6'h1E, 6'h1B, 6'h18,
                                             6'h15, 6'h12, 6'h0F, 6'h03};
   localparam logic [23:0] SETTLE_EXP_TBL = {6'h18, 6'h15, 6'h12, 6'h03};
   localparam logic [15:0] INTERVAL_UNIT  = 16'h0100;

   // ************************************************************
   // Bus answers, states and carriers
   // ************************************************************
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      ST_AWAKE  = 2'b00,
      ST_SLEEP  = 2'b01,
      ST_SETTLE = 2'b10,
      ST_CALIB  = 2'b11
   } lpcal_state_e;

   typedef struct packed {
      logic [ADDR_W-1:0] awaddr;
      logic              awvalid;
      logic [DATA_W-1:0] wdata;
      logic [3:0]        wstrb;
      logic              wvalid;
      logic              bready;
      logic [ADDR_W-1:0] araddr;
      logic              arvalid;
      logic              rready;
   } lpcal_axil_req_s;

   typedef struct packed {
      logic              awready;
      logic              wready;
      logic [1:0]        bresp;
      logic              bvalid;
      logic              arready;
      logic [DATA_W-1:0] rdata;
      logic [1:0]        rresp;
      logic              rvalid;
   } lpcal_axil_rsp_s;

   typedef struct packed {
      logic       en;
      logic [9:0] idx;
      logic [7:0] data;
   } lpcal_regwr_s;

   // Mapped register indices
   function automatic logic lpcal_is_mapped(input logic [9:0] idx);
      return (idx == IDX_LP_CTRL) || (idx == IDX_VEC_EN) ||
             (idx == IDX_CFG) || (idx == IDX_STATUS);
   endfunction : lpcal_is_mapped

endpackage : lpcal_pkg

// ===== rtl/lpcal_axil_slave.sv
// Purpose: AXI4-Lite slave front end for the calibration sequencer registers
// Assumes: Byte lane 0 carries the 8-bit register data
// Notes:   Unmapped addresses answer SLVERR, reads of them return zero
`timescale 1ns/1ns
module lpcal_axil_slave (
   // Clock and reset
   input  wire logic                      sys_clk_i,
   input  wire logic                      reset_n_i,
   // Bus
   input  wire lpcal_pkg::lpcal_axil_req_s axil_req_i,
   output lpcal_pkg::lpcal_axil_rsp_s      axil_rsp_o,
   // Register side
   output lpcal_pkg::lpcal_regwr_s         reg_wr_o,
   output logic [9:0]                      rd_idx_o,
   input  wire logic [7:0]                 rd_data_i
);
   logic       aw_got;
   logic       w_got;
   logic [9:0] aw_idx;
   logic [7:0] w_byte;
   logic       w_lane;
   logic       bvalid;
   logic [1:0] bresp;
   logic       rvalid;
   logic [1:0] rresp;
   logic [7:0] rdata;
   logic       aw_take;
   logic       w_take;
   logic       do_wr;

   // Handshakes; a new write waits until the previous response is taken
   assign aw_take  = axil_req_i.awvalid && !aw_got && !bvalid;
   assign w_take   = axil_req_i.wvalid && !w_got && !bvalid;
   assign do_wr    = aw_got && w_got;
   assign rd_idx_o = axil_req_i.araddr[11:2];

   // Address and data are latched apart so either may come first
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         aw_got <= 1'b0;
         w_got  <= 1'b0;
         aw_idx <= 10'h000;
         w_byte <= 8'h00;
         w_lane <= 1'b0;
      end else begin
         if (aw_take) begin
            aw_got <= 1'b1;
            aw_idx <= axil_req_i.awaddr[11:2];
         end else if (do_wr) begin
            aw_got <= 1'b0;
         end
         if (w_take) begin
            w_got  <= 1'b1;
            w_byte <= axil_req_i.wdata[7:0];
            w_lane <= axil_req_i.wstrb[0];
         end else if (do_wr) begin
            w_got <= 1'b0;
         end
      end
   end

   // Write response stands until bready
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         bvalid <= 1'b0;
         bresp  <= lpcal_pkg::RESP_OKAY;
      end else if (do_wr) begin
         bvalid <= 1'b1;
         bresp  <= lpcal_pkg::lpcal_is_mapped(aw_idx) ? lpcal_pkg::RESP_OKAY
                                                      : lpcal_pkg::RESP_SLVERR;
      end else if (bvalid && axil_req_i.bready) begin
         bvalid <= 1'b0;
      end
   end

   // Read data is captured at the address edge and stands until rready
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         rvalid <= 1'b0;
         rresp  <= lpcal_pkg::RESP_OKAY;
         rdata  <= 8'h00;
      end else if (axil_req_i.arvalid && !rvalid) begin
         rvalid <= 1'b1;
         rdata  <= rd_data_i;
         rresp  <= lpcal_pkg::lpcal_is_mapped(rd_idx_o) ? lpcal_pkg::RESP_OKAY
                                                        : lpcal_pkg::RESP_SLVERR;
      end else if (rvalid && axil_req_i.rready) begin
         rvalid <= 1'b0;
      end
   end

   // Outputs
   assign reg_wr_o.en        = do_wr && w_lane;
   assign reg_wr_o.idx       = aw_idx;
   assign reg_wr_o.data      = w_byte;
   assign axil_rsp_o.awready = !aw_got && !bvalid;
   assign axil_rsp_o.wready  = !w_got && !bvalid;
   assign axil_rsp_o.bresp   = bresp;
   assign axil_rsp_o.bvalid  = bvalid;
   assign axil_rsp_o.arready = !rvalid;
   assign axil_rsp_o.rdata   = {24'h000000, rdata};
   assign axil_rsp_o.rresp   = rresp;
   assign axil_rsp_o.rvalid  = rvalid;

endmodule : lpcal_axil_slave

// ===== rtl/lpcal_interval_timer.sv
// Purpose: Down counter that times one sequencer phase
// Assumes: load_val_i is at least 1
// Notes:   done_o rises load_val_i - 1 cycles after the loading edge
`timescale 1ns/1ns
module lpcal_interval_timer #(
   parameter int unsigned CNT_W = 48
) (
   // Clock and reset
   input  wire logic             sys_clk_i,
   input  wire logic             reset_n_i,
   // Control
   input  wire logic             load_i,
   input  wire logic [CNT_W-1:0] load_val_i,
   output logic [CNT_W-1:0]      count_o,
   output logic                  done_o
);
   // Count to zero and hold there
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         count_o <= '0;
      end else if (load_i) begin
         count_o <= load_val_i - CNT_W'(1);
      end else if (count_o != '0) begin
         count_o <= count_o - CNT_W'(1);
      end
   end

   assign done_o = (count_o == '0);

endmodule : lpcal_interval_timer

// ===== rtl/lpcal_ctrl.sv
// Purpose: Low-power background calibration sequencer with its registers
// Assumes: Calibration engine answers each request with calib_done_i
// Notes:   Exponent tables and unit are parameters so simulation can shorten phases
//
// Summary of operation
// - Sleep code picks (2^k+1)*256 sleep periods
// - Sleep code counts only in enabled autonomous mode
// - Settle code picks (2^k+1)*256 settle periods
// - Settle interval follows every timed or triggered wake-up
// - Trigger select clear means autonomous timed sleep
// - Trigger mode: sleep until trigger is low
// - Low-power enable resets clear, cores awake
// - Low-power enable needs background calibration on
// - Control register resets to 0x88
// - Vector enable bit opens the data port
// - Trigger source: pin or software bit
`timescale 1ns/1ns
module lpcal_ctrl #(
   parameter int unsigned NUM_CORES     = 2,
   parameter logic [47:0] SLEEP_EXP     = lpcal_pkg::SLEEP_EXP_TBL,
   parameter logic [23:0] SETTLE_EXP    = lpcal_pkg::SETTLE_EXP_TBL,
   parameter logic [15:0] INTERVAL_UNIT = lpcal_pkg::INTERVAL_UNIT
) (
   // Clock and reset
   input  wire logic                       sys_clk_i,
   input  wire logic                       reset_n_i,
   // Register bus
   input  wire lpcal_pkg::lpcal_axil_req_s axil_req_i,
   output lpcal_pkg::lpcal_axil_rsp_s      axil_rsp_o,
   // Trigger and calibration engine
   input  wire logic                       calib_trigger_pin_i,
   input  wire logic                       calib_done_i,
   // Core control
   output logic [NUM_CORES-1:0]            core_sleep_o,
   output logic [NUM_CORES-1:0]            core_calib_o,
   output logic                            calib_vector_port_en_o
);
   localparam int unsigned CNT_W = lpcal_pkg::CNT_W;
   localparam int unsigned IDX_W = (NUM_CORES > 1) ? $clog2(NUM_CORES) : 1;

   // ************************************************************
   // Parameter checks
   // ************************************************************
   if (NUM_CORES < 1 || NUM_CORES > 16) begin : g_bad_cores
      $error("NUM_CORES must lie between 1 and 16");
   end
   if (INTERVAL_UNIT == 16'h0000) begin : g_bad_unit
      $error("INTERVAL_UNIT must not be zero");
   end

   // ************************************************************
   // Declarations
   // ************************************************************
   lpcal_pkg::lpcal_regwr_s reg_wr;
   lpcal_pkg::lpcal_state_e state;
   lpcal_pkg::lpcal_state_e next_state;
   logic [7:0]              lp_ctrl;
   logic [7:0]              vec_en;
   logic [7:0]              cfg;
   logic [9:0]              rd_idx;
   logic [7:0]              rd_data;
   logic [7:0]              status;
   logic                    trig_meta;
   logic                    trig_sync;
   logic                    trig_sel;
   logic                    lp_active;
   logic                    wake_on_trig;
   logic [2:0]              sleep_code;
   logic [1:0]              settle_code;
   logic [5:0]              sleep_k;
   logic [5:0]              settle_k;
   logic [CNT_W-1:0]        sleep_len;
   logic [CNT_W-1:0]        settle_len;
   logic                    tmr_load;
   logic [CNT_W-1:0]        tmr_val;
   logic [CNT_W-1:0]        tmr_cnt;
   logic                    tmr_done;
   logic [IDX_W-1:0]        core_idx;
   logic [IDX_W-1:0]        next_core_idx;

   // ************************************************************
   // Register bus front end
   // ************************************************************
   lpcal_axil_slave u_slave (
      .sys_clk_i  (sys_clk_i),
      .reset_n_i  (reset_n_i),
      .axil_req_i (axil_req_i),
      .axil_rsp_o (axil_rsp_o),
      .reg_wr_o   (reg_wr),
      .rd_idx_o   (rd_idx),
      .rd_data_i  (rd_data)
   );

   // Control register, reserved bit 2 kept as plain storage
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         lp_ctrl <= lpcal_pkg::LP_CTRL_RST;
      end else if (reg_wr.en && reg_wr.idx == lpcal_pkg::IDX_LP_CTRL) begin
         lp_ctrl <= reg_wr.data;
      end
   end

   // Vector access enable register
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         vec_en <= lpcal_pkg::VEC_EN_RST;
      end else if (reg_wr.en && reg_wr.idx == lpcal_pkg::IDX_VEC_EN) begin
         vec_en <= reg_wr.data;
      end
   end

   // Configuration: background enable, trigger source, software trigger
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         cfg <= lpcal_pkg::CFG_RST;
      end else if (reg_wr.en && reg_wr.idx == lpcal_pkg::IDX_CFG) begin
         cfg <= {5'h00, reg_wr.data[2:0]};
      end
   end

   // Status shows the sequencer itself
   assign status = {4'(core_idx), trig_sel, lp_active, state};

   // Read decode; unmapped indices read zero
   always_comb begin
      case (rd_idx)
         lpcal_pkg::IDX_LP_CTRL: rd_data = lp_ctrl;
         lpcal_pkg::IDX_VEC_EN:  rd_data = vec_en;
         lpcal_pkg::IDX_CFG:     rd_data = cfg;
         lpcal_pkg::IDX_STATUS:  rd_data = status;
         default:                rd_data = 8'h00;
      endcase
   end

   // ************************************************************
   // Trigger selection
   // ************************************************************
   // Pin is asynchronous to the sampling clock: two flops first
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         trig_meta <= 1'b1;
         trig_sync <= 1'b1;
      end else begin
         trig_meta <= calib_trigger_pin_i;
         trig_sync <= trig_meta;
      end
   end

   // The source not selected has no effect at all
   assign trig_sel = cfg[lpcal_pkg::SRC_SEL_BIT] ? trig_sync
                                                 : cfg[lpcal_pkg::SOFT_TRG_BIT];

   // ************************************************************
   // Mode decode and interval lengths
   // ************************************************************
   // Low-power enable is ignored while background calibration is off
   assign lp_active    = lp_ctrl[lpcal_pkg::LP_ON_BIT]
                         && cfg[lpcal_pkg::BG_ON_BIT];
   assign wake_on_trig = lp_ctrl[lpcal_pkg::WAKE_TRG_BIT];
   assign sleep_code   = lp_ctrl[lpcal_pkg::SLEEP_LSB +: 3];
   assign settle_code  = lp_ctrl[lpcal_pkg::SETTLE_LSB +: 2];
   assign sleep_k      = SLEEP_EXP[6*sleep_code +: 6];
   assign settle_k     = SETTLE_EXP[6*settle_code +: 6];

   // 48 bits hold the longest sleep, (2^33+1)*256 periods
   assign sleep_len  = ((CNT_W'(1) << sleep_k) + CNT_W'(1))
                       * CNT_W'(INTERVAL_UNIT);
   assign settle_len = ((CNT_W'(1) << settle_k) + CNT_W'(1))
                       * CNT_W'(INTERVAL_UNIT);

   // ************************************************************
   // Phase timer
   // ************************************************************
   lpcal_interval_timer #(
      .CNT_W (CNT_W)
   ) u_timer (
      .sys_clk_i  (sys_clk_i),
      .reset_n_i  (reset_n_i),
      .load_i     (tmr_load),
      .load_val_i (tmr_val),
      .count_o    (tmr_cnt),
      .done_o     (tmr_done)
   );

   // ************************************************************
   // Sequencer
   // ************************************************************
   // Next state; timer restarts on each entry to sleep or settle
   always_comb begin
      next_state    = state;
      next_core_idx = core_idx;
      tmr_load      = 1'b0;
      tmr_val       = sleep_len;
      if (!lp_active) begin
         next_state = lpcal_pkg::ST_AWAKE;
      end else begin
         case (state)
            lpcal_pkg::ST_AWAKE: begin
               next_state = lpcal_pkg::ST_SLEEP;
               tmr_load   = 1'b1;
            end
            lpcal_pkg::ST_SLEEP: begin
               // Trigger mode never looks at the sleep timer
               if (wake_on_trig ? !trig_sel : tmr_done) begin
                  next_state = lpcal_pkg::ST_SETTLE;
                  tmr_load   = 1'b1;
                  tmr_val    = settle_len;
               end
            end
            lpcal_pkg::ST_SETTLE: begin
               if (tmr_done) begin
                  next_state = lpcal_pkg::ST_CALIB;
               end
            end
            lpcal_pkg::ST_CALIB: begin
               if (calib_done_i) begin
                  next_state = lpcal_pkg::ST_SLEEP;
                  tmr_load   = 1'b1;
                  if (core_idx == IDX_W'(NUM_CORES - 1)) begin
                     next_core_idx = '0;
                  end else begin
                     next_core_idx = core_idx + IDX_W'(1);
                  end
               end
            end
            default: begin
               next_state = lpcal_pkg::ST_AWAKE;
            end
         endcase
      end
   end

   // State register
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         state <= lpcal_pkg::ST_AWAKE;
      end else begin
         state <= next_state;
      end
   end

   // Core pointer; a fresh enable starts over at core 0
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         core_idx <= '0;
      end else if (!lp_active) begin
         core_idx <= '0;
      end else begin
         core_idx <= next_core_idx;
      end
   end

   // ************************************************************
   // Core outputs, registered to keep the analog controls glitch free
   // ************************************************************
   for (genvar c = 0; c < NUM_CORES; c++) begin : g_core
      always_ff @(posedge sys_clk_i) begin
         if (!reset_n_i) begin
            core_sleep_o[c] <= 1'b0;
            core_calib_o[c] <= 1'b0;
         end else begin
            core_sleep_o[c] <= (next_state == lpcal_pkg::ST_SLEEP)
                               && (next_core_idx == IDX_W'(c));
            core_calib_o[c] <= (next_state == lpcal_pkg::ST_CALIB)
                               && (next_core_idx == IDX_W'(c));
         end
      end
   end

   // Data port gate follows the vector enable bit
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         calib_vector_port_en_o <= 1'b0;
      end else begin
         calib_vector_port_en_o <= vec_en[lpcal_pkg::VEC_EN_BIT];
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);

   sequence s_enter_sleep;
      state != lpcal_pkg::ST_SLEEP ##1 state == lpcal_pkg::ST_SLEEP;
   endsequence

   sequence s_leave_sleep;
      state == lpcal_pkg::ST_SLEEP ##1 state != lpcal_pkg::ST_SLEEP;
   endsequence

   sequence s_vec_write_one;
      reg_wr.en && reg_wr.idx == lpcal_pkg::IDX_VEC_EN && reg_wr.data[0];
   endsequence

   chk_ctrl_reset_val: assert property (
      $rose(reset_n_i) |-> lp_ctrl == 8'h88 && vec_en == 8'h00)
      else $error("control registers wrong after reset");

   chk_off_stays_awake: assert property (
      !lp_active |=> core_sleep_o == '0 && core_calib_o == '0)
      else $error("core asleep while low-power sequencing is off");

   chk_bg_gates_enable: assert property (
      lp_ctrl[0] && !cfg[0] |=> state == lpcal_pkg::ST_AWAKE)
      else $error("sequencer ran without background calibration");

   chk_sleep_length: assert property (
      s_enter_sleep |-> tmr_cnt == $past(sleep_len) - 48'h000000000001)
      else $error("sleep interval loaded with wrong length");

   chk_settle_after: assert property (
      s_leave_sleep |-> state == lpcal_pkg::ST_SETTLE ||
                        state == lpcal_pkg::ST_AWAKE)
      else $error("wake-up not followed by settle interval");

   chk_settle_length: assert property (
      state == lpcal_pkg::ST_SLEEP ##1 state == lpcal_pkg::ST_SETTLE
      |-> tmr_cnt == $past(settle_len) - 48'h000000000001)
      else $error("settle interval loaded with wrong length");

   chk_auto_timed: assert property (
      state == lpcal_pkg::ST_SLEEP && !wake_on_trig && !tmr_done
      |=> state != lpcal_pkg::ST_SETTLE)
      else $error("autonomous sleep ended before its interval");

   chk_trig_holds: assert property (
      state == lpcal_pkg::ST_SLEEP && wake_on_trig && trig_sel && tmr_done
      |=> state != lpcal_pkg::ST_SETTLE)
      else $error("trigger mode woke on the sleep timer");

   chk_trig_wakes: assert property (
      lp_active && state == lpcal_pkg::ST_SLEEP && wake_on_trig && !trig_sel
      |=> state == lpcal_pkg::ST_SETTLE)
      else $error("low trigger did not wake the core");

   chk_core_advance: assert property (
      lp_active && state == lpcal_pkg::ST_CALIB && calib_done_i
      |=> state == lpcal_pkg::ST_SLEEP && core_sleep_o[core_idx]
          && core_idx == (($past(core_idx) == IDX_W'(NUM_CORES - 1)) ? '0
                          : $past(core_idx) + IDX_W'(1)))
      else $error("sequencer did not move to the next core");

   chk_vector_gate: assert property (
      s_vec_write_one |=> ##1 calib_vector_port_en_o)
      else $error("vector data port not opened by enable bit");

endmodule : lpcal_ctrl

// ===== verif/tb_lowpower_bg_calib_sleep_ctrl.sv
// Purpose: Self-checking bench for the low-power calibration sequencer
// Assumes: Shortened phase tables, sleep k = code, settle k = code, unit 2
// Notes:   Bus tasks wait on the handshakes; the watchdog ends a hang
`timescale 1ns/1ns
module tb_lowpower_bg_calib_sleep_ctrl;
   logic                       sys_clk     = 1'b0;
   logic                       reset_n     = 1'b0;
   logic                       trig_pin    = 1'b1;
   logic                       calib_done  = 1'b0;
   lpcal_pkg::lpcal_axil_req_s req         = '0;
   lpcal_pkg::lpcal_axil_rsp_s rsp;
   logic [1:0]                 core_sleep;
   logic [1:0]                 core_calib;
   logic                       port_en;
   int                         mismatches  = 0;
   int                         n_checks    = 0;
   logic [31:0]                rdat;
   logic [1:0]                 rrsp;
   int                         n;

   // Short tables keep every timed phase to at most 258 cycles
   lpcal_ctrl #(.NUM_CORES(2), .SLEEP_EXP({6'h07, 6'h06, 6'h05, 6'h04, 6'h03, 6'h02, 6'h01,
      6'h00}), .SETTLE_EXP({6'h03, 6'h02, 6'h01, 6'h00}), .INTERVAL_UNIT(16'h0002)) dut (
      .sys_clk_i(sys_clk), .reset_n_i(reset_n), .axil_req_i(req), .axil_rsp_o(rsp),
      .calib_trigger_pin_i(trig_pin), .calib_done_i(calib_done), .core_sleep_o(core_sleep),
      .core_calib_o(core_calib), .calib_vector_port_en_o(port_en));

   // 25 MHz clock
   always #20 sys_clk = ~sys_clk;

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR %s exp %h got %h", nm, e, g);
      end
   endtask : chk

   task automatic close_out;
      if (mismatches == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : close_out

   // Write with both channels offered together, each released when taken
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic aw;
      logic w;
      aw = 1'b1;
      w = 1'b1;
      @(posedge sys_clk);
      req.awaddr <= a;
      req.wdata <= {24'h000000, d};
      req.wstrb <= 4'hF;
      req.awvalid <= 1'b1;
      req.wvalid <= 1'b1;
      req.bready <= 1'b1;
      while (aw || w) begin
         @(posedge sys_clk);
         if (aw && rsp.awready === 1'b1) begin aw = 1'b0; req.awvalid <= 1'b0; end
         if (w && rsp.wready === 1'b1) begin w = 1'b0; req.wvalid <= 1'b0; end
      end
      while (rsp.bvalid !== 1'b1) @(posedge sys_clk);
      chk("bresp", 32'h0, {30'h0, rsp.bresp});
      req.bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge sys_clk);
      req.araddr <= a;
      req.arvalid <= 1'b1;
      req.rready <= 1'b1;
      do @(posedge sys_clk); while (rsp.arready !== 1'b1);
      req.arvalid <= 1'b0;
      do @(posedge sys_clk); while (rsp.rvalid !== 1'b1);
      d = rsp.rdata;
      r = rsp.rresp;
      req.rready <= 1'b0;
   endtask : rd

   // Reset values, unmapped access, vector port enable
   task automatic t_regs;
      rd(12'h1B8, rdat, rrsp); chk("ctrl_rst", 32'h00000088, rdat);
      rd(12'h1C0, rdat, rrsp); chk("vec_rst", 32'h00000000, rdat);
      rd(12'h004, rdat, rrsp); chk("unmapped", {30'h0, lpcal_pkg::RESP_SLVERR}, {30'h0, rrsp});
      wr(12'h1C0, 8'h01);
      repeat (3) @(posedge sys_clk);
      chk("port_en", 32'h1, {31'h0, port_en});
   endtask : t_regs

   // Timed mode: enable gated by background bit, exact sleep and settle lengths
   task automatic t_auto;
      wr(12'h1B8, 8'h95);
      rd(12'h1B8, rdat, rrsp); chk("ctrl_rw", 32'h00000095, rdat);
      repeat (40) @(posedge sys_clk);
      chk("no_bg_sleep", 32'h0, {30'h0, core_sleep});
      wr(12'h200, 8'h01);
      while (core_sleep[0] !== 1'b1) @(posedge sys_clk);
      n = 0;
      while (core_sleep[0] === 1'b1) begin n++; @(posedge sys_clk); end
      chk("sleep_len", 32'h00000022, n);
      n = 0;
      while (core_calib[0] !== 1'b1) begin n++; @(posedge sys_clk); end
      chk("settle_len", 32'h0000000A, n);
      calib_done <= 1'b1;
      @(posedge sys_clk);
      calib_done <= 1'b0;
      n = 0;
      while (core_sleep[1] !== 1'b1 && n < 8) begin n++; @(posedge sys_clk); end
      chk("next_core", 32'h1, {31'h0, core_sleep[1]});
   endtask : t_auto

   // Trigger mode: soft bit low is ignored, pin low wakes the core
   task automatic t_trig;
      wr(12'h1B8, 8'h00);
      repeat (4) @(posedge sys_clk);
      chk("off_awake", 32'h0, {30'h0, core_sleep});
      wr(12'h200, 8'h03);
      wr(12'h1B8, 8'h8B);
      repeat (100) @(posedge sys_clk);
      chk("trig_hold", 32'h1, {31'h0, core_sleep[0]});
      // Status: core 0, pin trigger high, sequencing on, asleep
      rd(12'h204, rdat, rrsp); chk("status", 32'h0000000D, rdat);
      trig_pin <= 1'b0;
      repeat (8) @(posedge sys_clk);
      chk("trig_wake", 32'h0, {31'h0, core_sleep[0]});
      trig_pin <= 1'b1;
   endtask : t_trig

   initial begin
      repeat (12) @(posedge sys_clk);
      reset_n <= 1'b1;
      t_regs;
      t_auto;
      t_trig;
      close_out;
   end

   // Watchdog far beyond the expected run
   initial begin
      #800000;
      mismatches++;
      close_out;
   end
endmodule : tb_lowpower_bg_calib_sleep_ctrl
